// >>> rtl/simple_serial_port.v
// Purpose : byte-wide full-duplex three-wire serial port, master or slave
// Assumes : processor bus strobes are one-cycle pulses on clk
// Notes   : master-mode bytes, and slave bytes that find room, are also queued in an 8-word fifo for a stream consumer
`timescale 1ns/1ns
`default_nettype none

`include "simple_serial_port_map.vh"

module simple_serial_port #(
    parameter FIFO_DEPTH = `RX_FIFO_DEPTH
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // processor bus
    input  wire [7:0] bus_addr,
    input  wire [7:0] bus_wdata,
    input  wire       bus_wr,
    input  wire       bus_rd,
    output reg  [7:0] bus_rdata,
    // processor state
    input  wire       irq_mask,
    input  wire       stop_mode,
    output reg        irq_req,
    output reg        wake_req,
    // general purpose port logic for pins 0-2
    input  wire [2:0] gpio_out,
    input  wire [2:0] gpio_dir,
    // pins 0 data in, 1 data out, 2 serial clock
    input  wire [2:0] pin_in,
    output reg  [2:0] pin_out,
    output reg  [2:0] pin_oe,
    // received byte stream
    output wire       rx_valid,
    input  wire       rx_ready,
    output wire [7:0] rx_data
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_WAIT  = 3'b010;
    localparam ST_SHIFT = 3'b100;

    function [7:0] reverse8;
        input [7:0] v;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                reverse8[i] = v[7-i];
            end
        end
    endfunction

    // =================================================================
    // registers and state
    reg  [7:0] control_ff;
    reg  [7:0] shift_ff;
    reg        complete_ff;
    reg        collision_ff;
    reg        armed_ff;
    reg  [2:0] state_ff;
    reg  [2:0] pulse_cnt_ff;
    reg  [3:0] div_cnt_ff;
    reg        sck_ff;
    reg        sdo_ff;
    reg        slave_busy_ff;
    reg  [2:0] pin_s1_ff;
    reg  [2:0] pin_s2_ff;
    reg        sck_prev_ff;
    reg        push_ff;
    reg  [7:0] push_data_ff;

    wire       irq_en    = control_ff[`CTL_IRQ_ENABLE_BIT];
    wire       enabled   = control_ff[`CTL_PORT_ENABLE_BIT];
    wire       lsb_first = control_ff[`CTL_BIT_ORDER_BIT];
    wire       master    = control_ff[`CTL_MASTER_SELECT_BIT];
    wire       rate_sel  = control_ff[`CTL_RATE_SELECT_BIT];

    wire       sdi_s     = pin_s2_ff[0];
    wire       sck_s     = pin_s2_ff[2];
    wire       fifo_ready;

    wire       sel_ctl   = (bus_addr == `SERIAL_CONTROL_ADDR);
    wire       sel_sts   = (bus_addr == `SERIAL_STATUS_ADDR);
    wire       sel_dat   = (bus_addr == `SERIAL_SHIFT_DATA_ADDR);
    wire       dat_acc   = sel_dat && (bus_wr || bus_rd);
    wire       busy      = enabled && ((state_ff == ST_SHIFT) || (state_ff == ST_WAIT) || slave_busy_ff);

    wire [3:0] half_per  = rate_sel ? `HALF_PERIOD_DIV16 : `HALF_PERIOD_DIV2;
    wire       div_hit   = (div_cnt_ff == half_per - 4'h1);

    // master edges come from the divider, slave edges from the pin
    wire m_edge    = enabled && master && (state_ff == ST_SHIFT) && div_hit;
    wire m_rise    = m_edge && !sck_ff;
    wire m_fall    = m_edge && sck_ff;
    wire s_active  = enabled && !master && !complete_ff;
    wire s_rise    = s_active && sck_s && !sck_prev_ff;
    wire s_fall    = s_active && !sck_s && sck_prev_ff;
    wire rise      = m_rise || s_rise;
    wire fall      = m_fall || (s_fall && slave_busy_ff) || (s_fall && !slave_busy_ff);
    wire last_bit  = rise && (pulse_cnt_ff == 3'h7);
    wire load_ok   = bus_wr && sel_dat && !busy && !complete_ff;
    wire clear_seq = armed_ff && dat_acc;

    // =================================================================
    // pin synchronisers
    always @(posedge clk) begin
        if (rst) begin
            pin_s1_ff   <= 3'h7;
            pin_s2_ff   <= 3'h7;
            sck_prev_ff <= 1'b1;
        end else begin
            pin_s1_ff   <= pin_in;
            pin_s2_ff   <= pin_s1_ff;
            sck_prev_ff <= sck_s;
        end
    end

    // =================================================================
    // control register
    always @(posedge clk) begin
        if (rst) begin
            control_ff <= `CTL_RESET;
        end else if (bus_wr && sel_ctl) begin
            control_ff <= bus_wdata & `CTL_WRITE_MASK;
        end
    end

    // =================================================================
    // shift register and serial data out
    always @(posedge clk) begin
        if (rst) begin
            shift_ff <= 8'h00;
            sdo_ff   <= 1'b1;
        end else if (load_ok) begin
            // held msb first internally, so the bus sees the chosen orientation
            shift_ff <= lsb_first ? reverse8(bus_wdata) : bus_wdata;
            sdo_ff   <= lsb_first ? bus_wdata[0] : bus_wdata[7];
        end else if (rise) begin
            shift_ff <= {shift_ff[6:0], sdi_s};
        end else if (fall) begin
            sdo_ff   <= shift_ff[7];
        end
    end

    // =================================================================
    // transfer sequencing, master clock generator and pulse counter
    always @(posedge clk) begin
        if (rst || !enabled) begin
            state_ff      <= ST_IDLE;
            div_cnt_ff    <= 4'h0;
            sck_ff        <= 1'b1;
            pulse_cnt_ff  <= 3'h0;
            slave_busy_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    div_cnt_ff <= 4'h0;
                    sck_ff     <= 1'b1;
                    if (load_ok && master) begin
                        state_ff <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // hold the start until the receive queue has room
                    if (fifo_ready) begin
                        state_ff <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (div_hit) begin
                        div_cnt_ff <= 4'h0;
                        sck_ff     <= !sck_ff;
                        if (last_bit) begin
                            state_ff <= ST_IDLE;
                        end
                    end else begin
                        div_cnt_ff <= div_cnt_ff + 4'h1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
            if (s_fall) begin
                slave_busy_ff <= 1'b1;
            end else if (last_bit) begin
                slave_busy_ff <= 1'b0;
            end
            if (rise) begin
                pulse_cnt_ff <= pulse_cnt_ff + 3'h1;
            end
        end
    end

    // =================================================================
    // status flags
    always @(posedge clk) begin
        if (rst || !enabled) begin
            complete_ff  <= 1'b0;
            collision_ff <= 1'b0;
            armed_ff     <= 1'b0;
        end else begin
            // a new event in the clearing cycle wins over the clear
            if (last_bit) begin
                complete_ff <= 1'b1;
            end else if (clear_seq) begin
                complete_ff <= 1'b0;
            end
            if (dat_acc && busy) begin
                collision_ff <= 1'b1;
            end else if (clear_seq) begin
                collision_ff <= 1'b0;
            end
            if (bus_rd && sel_sts && complete_ff) begin
                armed_ff <= 1'b1;
            end else if (dat_acc || !complete_ff) begin
                armed_ff <= 1'b0;
            end
        end
    end

    // =================================================================
    // receive queue feed
    always @(posedge clk) begin
        if (rst) begin
            push_ff      <= 1'b0;
            push_data_ff <= 8'h00;
        end else begin
            push_ff      <= last_bit && fifo_ready;
            push_data_ff <= lsb_first ? reverse8({shift_ff[6:0], sdi_s}) : {shift_ff[6:0], sdi_s};
        end
    end

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push_ff),
        .in_ready  (fifo_ready),
        .in_data   (push_data_ff),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // =================================================================
    // bus read data
    always @(posedge clk) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            if (sel_ctl) begin
                bus_rdata <= control_ff;
            end else if (sel_sts) begin
                bus_rdata <= {complete_ff, collision_ff, 6'h00};
            end else if (sel_dat) begin
                bus_rdata <= lsb_first ? reverse8(shift_ff) : shift_ff;
            end else begin
                bus_rdata <= 8'h00;
            end
        end
    end

    // =================================================================
    // interrupt and wake
    always @(posedge clk) begin
        if (rst) begin
            irq_req  <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            irq_req  <= complete_ff && irq_en && !irq_mask && (!stop_mode || !master);
            wake_req <= complete_ff && irq_en && stop_mode && !master;
        end
    end

    // =================================================================
    // pin ownership
    always @(posedge clk) begin
        if (rst) begin
            pin_out <= 3'h0;
            pin_oe  <= 3'h0;
        end else if (enabled) begin
            pin_out <= {sck_ff, sdo_ff, 1'b0};
            pin_oe  <= {master, 1'b1, 1'b0};
        end else begin
            pin_out <= gpio_out;
            pin_oe  <= gpio_dir;
        end
    end

endmodule

`default_nettype wire

// >>> pkg/simple_serial_port_map.vh
// Purpose : register map, field positions and timing counts of the serial port
// Assumes : byte-wide processor bus, 8-bit registers
// Notes   : definitions only
`ifndef SIMPLE_SERIAL_PORT_MAP_VH
`define SIMPLE_SERIAL_PORT_MAP_VH

// =====================================================================
// register offsets
`define SERIAL_CONTROL_ADDR    8'h0a
`define SERIAL_STATUS_ADDR     8'h0b
`define SERIAL_SHIFT_DATA_ADDR 8'h0c

// =====================================================================
// serial_control fields
`define CTL_IRQ_ENABLE_BIT     7
`define CTL_PORT_ENABLE_BIT    6
`define CTL_BIT_ORDER_BIT      5
`define CTL_MASTER_SELECT_BIT  4
`define CTL_RATE_SELECT_BIT    0
`define CTL_WRITE_MASK         8'hf1
`define CTL_RESET              8'h00

// =====================================================================
// serial_status fields
`define STS_COMPLETE_BIT       7
`define STS_COLLISION_BIT      6

// =====================================================================
// serial clock half periods in processor clocks (divide by 2 and by 16)
`define HALF_PERIOD_DIV2       4'h1
`define HALF_PERIOD_DIV16      4'h8

// =====================================================================
// byte length and receive fifo depth
`define BITS_PER_BYTE          8
`define RX_FIFO_DEPTH          8

`endif

// >>> rtl/byte_fifo.v
// Purpose : small synchronous fifo with valid and ready on both sides
// Assumes : one clock, synchronous active high reset
// Notes   : depth must be a power of two
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_ff;
    reg [AW:0]      rd_ptr_ff;

    wire full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    wire empty = (wr_ptr_ff == rd_ptr_ff);
    wire push  = in_valid && !full;
    wire pop   = out_ready && !empty;

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr_ff[AW-1:0]];

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> tb/serial_peer_model.sv
// Purpose : remote serial device that the port talks to in master mode and in slave mode
// Assumes : clock idles high, first bit is held from load until the first rise
// Notes   : serial order is recorded first-bit-in-msb whatever the port's order
`timescale 1ns/1ns
`default_nettype none

module serial_peer_model (
    // serial lines
    input  wire logic       sck,
    input  wire logic       serial_data_out,
    output logic            serial_data_in,
    // bench side
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte,
    output logic [3:0]      rises
);
    logic [7:0] sh;

    initial begin
        serial_data_in = 1'b1;
        rx_byte = 8'h00;
        rises = 4'h0;
        sh = 8'h00;
    end

    always @(posedge load) begin
        sh = tx_byte;
        serial_data_in = tx_byte[7];
        rises = 4'h0;
    end

    // sample on rises, shift only in step with the supplied clock
    always @(posedge sck) begin
        if (rises < 4'h8) begin
            rx_byte = {rx_byte[6:0], serial_data_out};
            rises = rises + 4'h1;
            if (rises == 4'h8) begin
                #40;
                serial_data_in = ~serial_data_in;
            end
        end
    end

    // next bit goes out on each falling edge inside the byte
    always @(negedge sck) begin
        if (rises > 4'h0 && rises < 4'h8) begin
            sh = {sh[6:0], 1'b0};
            serial_data_in = sh[7];
        end
    end
endmodule

`default_nettype wire

// >>> tb/serial_port_assertions.sv
// Purpose : port-level checks of the serial port
// Assumes : one clock, synchronous active high reset
// Notes   : bound to every instance of the port
`timescale 1ns/1ns
`default_nettype none

module serial_port_checker #(
    parameter FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // processor side
    input wire logic [7:0] bus_addr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic       irq_mask,
    input wire logic       stop_mode,
    input wire logic       irq_req,
    input wire logic       wake_req,
    // pins and stream
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_dir,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic [7:0] rx_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // =====================================================================
    // assertions
    a_irq_masked: assert property (irq_req |-> !$past(irq_mask))
        else $error("interrupt raised while masked");
    a_wake_stop: assert property (wake_req |-> $past(stop_mode))
        else $error("wakeup outside stop");
    a_wake_with_irq: assert property (wake_req && !$past(irq_mask) |-> irq_req)
        else $error("wakeup without its interrupt");
    a_rdata_hold: assert property (!$past(bus_rd) |-> $stable(bus_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (bus_rd && (bus_addr < 8'h0a || bus_addr > 8'h0c) |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctl_reserved: assert property (bus_rd && bus_addr == 8'h0a |=> bus_rdata[3:1] == 3'h0)
        else $error("control reserved bits not zero");
    a_status_reserved: assert property (bus_rd && bus_addr == 8'h0b |=> bus_rdata[5:0] == 6'h00)
        else $error("status reserved bits not zero");
    a_data_pin_input: assert property (pin_oe[0] |-> $past(gpio_dir[0]) && pin_out[0] == $past(gpio_out[0]))
        else $error("data in pin driven by the port");
    a_sck_low_time: assert property ($fell(pin_out[2]) && pin_oe[2] |=>
        pin_out[2] or (!pin_out[2] [*7] ##1 pin_out[2]))
        else $error("serial clock low phase wrong");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("stream byte lost while stalled");

    c_irq: cover property ($rose(irq_req));
    c_pop: cover property (rx_valid && rx_ready);
    c_sck: cover property ($fell(pin_out[2]) && pin_oe[2]);
endmodule

bind simple_serial_port serial_port_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk(clk), .rst(rst),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq_mask(irq_mask),
    .stop_mode(stop_mode), .irq_req(irq_req), .wake_req(wake_req), .gpio_out(gpio_out),
    .gpio_dir(gpio_dir), .pin_out(pin_out), .pin_oe(pin_oe), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data));

`default_nettype wire

// >>> tb/simple_serial_port_test.sv
// Purpose : self-checking bench of the serial port in master mode, then one slave byte and a return to general purpose pins
// Assumes : remote peer on the pins, pull-ups on clock and data out
// Notes   : random bytes, orders, rates and interrupt settings from seed 38
`timescale 1ns/1ns
`default_nettype none

module simple_serial_port_test;
    logic       clk, rst, bus_wr, bus_rd, irq_mask, stop_mode, rx_ready, load, lsb, ien;
    logic [7:0] bus_addr, bus_wdata, d, w, ptx;
    logic       sclk;
    logic [2:0] gpio_out, gpio_dir;
    wire  [7:0] bus_rdata, rx_data, prx;
    wire  [2:0] pin_in, pin_out, pin_oe;
    wire  [3:0] rises;
    wire        irq_req, wake_req, rx_valid, serial_data_in;
    int         seed, bad_count, cmp_count, cycles, n, k, v;
    logic [7:0] q [$];

    // pull-ups keep the clock high before enabling
    assign pin_in = {pin_oe[2] ? pin_out[2] : sclk, pin_oe[1] ? pin_out[1] : 1'b1,
                     pin_oe[0] ? pin_out[0] : serial_data_in};

    simple_serial_port #(.FIFO_DEPTH(8)) DUT (.clk(clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .irq_mask(irq_mask), .stop_mode(stop_mode), .irq_req(irq_req), .wake_req(wake_req),
        .gpio_out(gpio_out), .gpio_dir(gpio_dir), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));

    serial_peer_model peer (.sck(pin_in[2]), .serial_data_out(pin_in[1]), .serial_data_in(serial_data_in), .load(load),
        .tx_byte(ptx), .rx_byte(prx), .rises(rises));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // =====================================================================
    // helpers
    task check(input [7:0] seen, input [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wr(input [7:0] a, input [7:0] dat);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= dat;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task rd(input [7:0] a, output [7:0] dat);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 dat = bus_rdata;
    endtask

    function [7:0] orient(input [7:0] x, input l);
        for (int i = 0; i < 8; i++) orient[i] = l ? x[7-i] : x[i];
    endfunction

    task wrap_up;
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up;
        end
    end

    // =====================================================================
    // main sequence
    initial begin
        seed = 38;
        {rst, bus_wr, bus_rd, irq_mask, stop_mode, rx_ready, load} = 7'h40;
        sclk = 1'b1;
        {bus_addr, bus_wdata, ptx} = 24'h0;
        gpio_out = 3'b100;
        gpio_dir = 3'b100;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(8'h0a, d); check(d, 8'h00);
        rd(8'h0b, d); check(d, 8'h00);
        rd(8'h0d, d); check(d, 8'h00);
        for (n = 0; n < 8; n++) begin
            v = $random(seed);
            {ien, lsb} = v[2:1];
            w = (n == 0) ? 8'h01 : 8'($random(seed));
            ptx = v[0] ? 8'($random(seed)) : {8{v[9]}};
            gpio_dir <= {1'b1, v[4:3]};
            gpio_out <= {1'b1, v[6:5]};
            irq_mask <= v[7];
            stop_mode <= v[8];
            load <= 1'b1;
            wr(8'h0a, {ien, 1'b1, lsb, 1'b1, 3'h0, v[0]});
            load <= 1'b0;
            repeat (2) @(posedge clk);
            #1 check({5'h0, pin_oe}, 8'h06);
            wr(8'h0c, w);
            wr(8'h0c, ~w);
            d = 8'h00;
            for (k = 0; k < 300 && !d[7]; k++) rd(8'h0b, d);
            check(d, 8'hc0);
            check({4'h0, rises}, 8'h08);
            check(prx, orient(w, lsb));
            check({7'h0, irq_req}, {7'h0, ien & !v[7] & !v[8]});
            check({7'h0, wake_req}, 8'h00);
            wr(8'h0c, 8'h5a);
            rd(8'h0c, d); check(d, orient(ptx, lsb));
            rd(8'h0b, d); check(d, 8'h00);
            check({7'h0, irq_req}, 8'h00);
            q.push_back(orient(ptx, lsb));
        end
        for (n = 0; n < 8; n++) begin
            #1 check({7'h0, rx_valid}, 8'h01);
            check(rx_data, q[n]);
            @(posedge clk) rx_ready <= 1'b1;
            @(posedge clk) rx_ready <= 1'b0;
        end
        #1 check({7'h0, rx_valid}, 8'h00);
        // slave byte: the bench clocks both ends, a ninth pulse must be ignored
        lsb = v[3];
        w = 8'($random(seed));
        ptx = 8'($random(seed));
        stop_mode <= 1'b1;
        irq_mask <= 1'b0;
        load <= 1'b1;
        wr(8'h0a, {2'h3, lsb, 1'b0, 4'h1});
        load <= 1'b0;
        wr(8'h0c, w);
        repeat (4) @(posedge clk);
        #1 check({5'h0, pin_oe}, 8'h02);
        for (k = 0; k < 9; k++) begin
            repeat (8) @(posedge clk);
            sclk <= 1'b0;
            repeat (8) @(posedge clk);
            sclk <= 1'b1;
        end
        repeat (4) @(posedge clk);
        #1 check({4'h0, rises}, 8'h08);
        check(prx, orient(w, lsb));
        check({6'h0, irq_req, wake_req}, 8'h03);
        rd(8'h0b, d); check(d, 8'h80);
        rd(8'h0c, d); check(d, orient(ptx, lsb));
        rd(8'h0b, d); check(d, 8'h00);
        check(rx_data, orient(ptx, lsb));
        stop_mode <= 1'b0;
        gpio_dir <= 3'b111;
        wr(8'h0a, 8'h00);
        repeat (2) @(posedge clk);
        #1 check({5'h0, pin_oe}, 8'h07);
        check({5'h0, pin_out}, {5'h0, gpio_out});
        rd(8'h0b, d); check(d, 8'h00);
        wrap_up;
    end
endmodule

`default_nettype wire
